// File: common/rst_pf_pkg.sv
/*
  Constants, register map and state encoding for the reset and powerfail block.
  Assumes a 32-bit APB slave port with an 8-bit byte address.
*/
package rst_pf_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_PCTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_MAP = 8'h08;
  localparam logic [7:0] ADDR_PRIO = 8'h0c;
  localparam logic [7:0] ADDR_PSR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // power controller control bits
  localparam int PCTRL_ALT_PF = 0;
  localparam int PCTRL_NO_BATT = 1;
  localparam int PCTRL_PSU_IE = 2;
  // command bits, write-one pulses
  localparam int CMD_IO_RESET = 0;
  localparam int CMD_INT_DISABLE = 1;
  localparam int CMD_INT_ENABLE = 2;
  localparam int CMD_CLEAR_PF = 3;
  localparam int CMD_CONTINUE = 4;
  // translation, memory checking and timer control fields
  localparam int MAP_XLATE_EN = 0;
  localparam int MAP_PAGE31_LSB = 8;
  localparam int MAP_ECC_CHECK = 16;
  localparam int MAP_ECC_SNIFF = 17;
  localparam int MAP_ECC_IE = 18;
  localparam int MAP_TIMER_RUN = 19;
  localparam int MAP_RTC_AC = 20;
  localparam int PSR_FP_LSB = 16;
  // values applied by a reset
  localparam logic [4:0] PAGE31_RESET = 5'h1f;
  localparam logic [15:0] PSR_RESET = 16'h0000;
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  // floating status bits 0..9, bit 0 being the most significant
  localparam logic [15:0] FPSR_CLR_MASK = 16'hffc0;
  localparam logic [2:0] PCTRL_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_CONSOLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DCLOW = 3'b100
  } cpuState_t;
endpackage

// File: common/pf_link_if.sv
/*
  Link between the reset sequencer and its powerfail interrupt unit.
  Assumes both ends share ref_clk and the synchronous sys_rst.
*/
`timescale 1ns/1ps
interface pf_link_if (
  input wire logic clk,
  input wire logic rst
);
  logic uvRise;
  logic restore;
  logic fullReset;
  logic clearPf;
  logic altMode;
  logic psuIntEn;
  logic ionOn;
  logic pfFlag;
  logic psuPend;
  logic nmiReq;
  logic psuReq;
  modport ctl (input clk, rst, pfFlag, psuPend, nmiReq, psuReq,
    output uvRise, restore, fullReset, clearPf, altMode, psuIntEn, ionOn);
  modport unit (input clk, rst, uvRise, restore, fullReset, clearPf, altMode, psuIntEn,
    ionOn, output pfFlag, psuPend, nmiReq, psuReq);
endinterface

// File: src/powerfail_irq_unit.sv
/*
  Powerfail flag and power controller interrupt request.
  Assumes event inputs on the link are single-cycle pulses on the link clock.
*/
`timescale 1ns/1ps
module powerfail_irq_unit
  import rst_pf_pkg::*;
(
  pf_link_if.unit lnk
);
  logic pfFlag_q;
  logic psuPend_q;

  default clocking cb @(posedge lnk.clk); endclocking
  default disable iff (lnk.rst);

  // set wins so an undervoltage in the clearing cycle is never lost
  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      pfFlag_q <= 1'b0;
    end else if (lnk.uvRise && !lnk.altMode) begin
      pfFlag_q <= 1'b1;
    end else if (lnk.clearPf || lnk.restore || lnk.fullReset) begin
      pfFlag_q <= 1'b0;
    end
  end

  // the controller's own request is raised even in alternate mode
  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      psuPend_q <= 1'b0;
    end else if (lnk.uvRise) begin
      psuPend_q <= 1'b1;
    end else if (lnk.clearPf || lnk.restore || lnk.fullReset) begin
      psuPend_q <= 1'b0;
    end
  end

  assign lnk.pfFlag = pfFlag_q;
  assign lnk.psuPend = psuPend_q;
  // interrupt-off blocks both, priority mask does not touch the powerfail one
  assign lnk.nmiReq = pfFlag_q && lnk.ionOn;
  assign lnk.psuReq = psuPend_q && lnk.psuIntEn && lnk.ionOn && !lnk.nmiReq;

  AST_UV_SETS_FLAG: assert property (lnk.uvRise && !lnk.altMode |=> pfFlag_q)
    else $error("undervoltage did not set powerfail flag");
  AST_ALT_NO_FLAG: assert property (lnk.uvRise && lnk.altMode && !pfFlag_q |=> !pfFlag_q)
    else $error("alternate mode still set powerfail flag");
  AST_CLEAR_PF: assert property (lnk.clearPf && !lnk.uvRise |=> !pfFlag_q)
    else $error("clear powerfail did not clear flag");
  AST_RESTORE_CLR: assert property (lnk.restore && !lnk.uvRise |=> !pfFlag_q && !psuPend_q)
    else $error("power restore left powerfail pending");
  AST_PSU_REQ: assert property (lnk.uvRise ##1
    (lnk.psuIntEn && lnk.ionOn && !pfFlag_q) |-> lnk.psuReq)
    else $error("controller request missing in alternate mode");
endmodule

// File: src/system_reset_powerfail_init.sv
/*
  Reset and powerfail sequencer: applies power-up, system and I/O reset state,
  steers console/run state on power loss and restore, and holds the power
  controller control register. Assumes a zero-wait APB master on ref_clk and
  pins that are already synchronous to ref_clk.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
// Notes on behaviour
// - power-up or system reset invalidates every cache entry; memory left indeterminate.
// - every reset turns address translation off, logical equals physical.
// - every reset loads translator page 31 entry with 31.
// - map tables are left untouched by power-up or system reset.
// - every reset enables check and sniff, disables memory-check interrupts.
// - every reset clears processor status and floating status bits 0-9.
// - power-up or system reset clears interrupt-on and the priority mask.
// - I/O reset clears the interrupt priority mask.
// - every reset clears all device busy and done flags.
// - every reset stops the interval timer.
// - every reset selects line frequency for the real-time clock.
// - power-up or system reset stops the program and enters console mode.
// - interrupt disable blocks all requests, power controller's included.
// - alternate powerfail mode stops the powerfail flag and its interrupt.
// - the controller's own powerfail request still reaches the processor when enabled.
// - disable-battery bit turns battery backup off.
// - DC collapse resets the system and stops execution.
// - power restore with battery clears the pending powerfail interrupt.
// - restore with locked panel resumes by jump through location 0.
// - restore with unlocked panel enters console and prompts; continue jumps through 0.
// - undervoltage sets powerfail flag and raises the non-maskable request; the controller request is held off while that one is up.
// - clear-powerfail command clears the pending powerfail interrupt.
`timescale 1ns/1ps
module system_reset_powerfail_init
  import rst_pf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power and panel pins
  input wire logic dcOk,
  input wire logic acUndervoltage,
  input wire logic batteryPresent,
  input wire logic panelLocked,
  input wire logic resetSwitch,
  // reset effects toward the processor
  output logic cacheInvalidate,
  output logic busyDoneClear,
  output logic translationEnable,
  output logic [4:0] page31Frame,
  output logic eccCheckEnable,
  output logic eccSniffEnable,
  output logic eccIntEnable,
  output logic [15:0] procStatus,
  output logic [15:0] fpStatus,
  output logic interruptOnFlag,
  output logic [15:0] ioPriorityMask,
  output logic intervalTimerRun,
  output logic rtcAcLineSelect,
  // execution control
  output logic consoleMode,
  output logic execStop,
  output logic jumpThroughZero,
  output logic consolePrompt,
  // power interrupts and backup
  output logic powerfailFlag,
  output logic powerfailNmi,
  output logic psuIntReq,
  output logic batteryBackupOn
);
  cpuState_t state_q;
  logic dcOkPrev_q;
  logic acUvPrev_q;
  logic [2:0] pctrl_q;
  logic cacheInv_q;
  logic busyDoneClr_q;
  logic xlate_q;
  logic [4:0] page31_q;
  logic eccCheck_q;
  logic eccSniff_q;
  logic eccIe_q;
  logic [15:0] psr_q;
  logic [15:0] fpsr_q;
  logic ion_q;
  logic [15:0] prio_q;
  logic timerRun_q;
  logic rtcAc_q;
  logic jumpZero_q;
  logic prompt_q;
  logic battOn_q;
  logic [31:0] prdata_q;
  logic dcRise;
  logic dcFall;
  logic uvRise;
  logic uvFall;
  logic fullApply;
  logic ioApply;
  logic anyApply;
  logic setupPh;
  logic wrAcc;
  logic mapped;
  logic cmdWr;
  logic intDisCmd;
  logic intEnCmd;
  logic clearPfCmd;
  logic continueCmd;
  logic restoreEvt;
  logic [31:0] rdValue;

  pf_link_if pfLink (.clk(ref_clk), .rst(sys_rst));

  powerfail_irq_unit pfUnit (
    .lnk(pfLink.unit)
  );

  // edge detection on the power pins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dcOkPrev_q <= 1'b0;
      acUvPrev_q <= 1'b0;
    end else begin
      dcOkPrev_q <= dcOk;
      acUvPrev_q <= acUndervoltage;
    end
  end

  // dcOk low at reset makes its first high sample count as the power-up reset
  assign dcRise = dcOk && !dcOkPrev_q;
  assign dcFall = !dcOk && dcOkPrev_q;
  assign uvRise = acUndervoltage && !acUvPrev_q;
  assign uvFall = !acUndervoltage && acUvPrev_q;
  assign fullApply = dcRise || dcFall || resetSwitch;

  // apb decode, zero wait states
  assign setupPh = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign mapped = (paddr == ADDR_PCTRL) || (paddr == ADDR_CMD) || (paddr == ADDR_MAP) ||
    (paddr == ADDR_PRIO) || (paddr == ADDR_PSR) || (paddr == ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign cmdWr = wrAcc && (paddr == ADDR_CMD);
  // a system reset in the same cycle swallows an I/O reset, it covers it anyway
  assign ioApply = cmdWr && pwdata[CMD_IO_RESET] && !fullApply;
  assign anyApply = fullApply || ioApply;
  assign intDisCmd = cmdWr && pwdata[CMD_INT_DISABLE];
  assign intEnCmd = cmdWr && pwdata[CMD_INT_ENABLE];
  assign clearPfCmd = cmdWr && pwdata[CMD_CLEAR_PF];
  assign continueCmd = cmdWr && pwdata[CMD_CONTINUE];
  // restore only counts while the rails held up on battery
  assign restoreEvt = uvFall && batteryPresent && (state_q != ST_DCLOW);

  // power controller control register, cleared by power-up and system reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pctrl_q <= PCTRL_RESET;
    end else if (fullApply) begin
      pctrl_q <= PCTRL_RESET;
    end else if (wrAcc && (paddr == ADDR_PCTRL)) begin
      pctrl_q <= pwdata[2:0];
    end
  end

  // one-cycle reset strobes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cacheInv_q <= 1'b1;
      busyDoneClr_q <= 1'b1;
    end else begin
      cacheInv_q <= fullApply;
      busyDoneClr_q <= anyApply;
    end
  end

  // translator: only the page 31 entry is forced, the map tables stay as they were
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xlate_q <= 1'b0;
      page31_q <= PAGE31_RESET;
    end else if (anyApply) begin
      xlate_q <= 1'b0;
      page31_q <= PAGE31_RESET;
    end else if (wrAcc && (paddr == ADDR_MAP)) begin
      xlate_q <= pwdata[MAP_XLATE_EN];
      page31_q <= pwdata[MAP_PAGE31_LSB +: 5];
    end
  end

  // memory checking, interval timer and clock source
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      eccCheck_q <= 1'b1;
      eccSniff_q <= 1'b1;
      eccIe_q <= 1'b0;
      timerRun_q <= 1'b0;
      rtcAc_q <= 1'b1;
    end else if (anyApply) begin
      eccCheck_q <= 1'b1;
      eccSniff_q <= 1'b1;
      eccIe_q <= 1'b0;
      timerRun_q <= 1'b0;
      rtcAc_q <= 1'b1;
    end else if (wrAcc && (paddr == ADDR_MAP)) begin
      eccCheck_q <= pwdata[MAP_ECC_CHECK];
      eccSniff_q <= pwdata[MAP_ECC_SNIFF];
      eccIe_q <= pwdata[MAP_ECC_IE];
      timerRun_q <= pwdata[MAP_TIMER_RUN];
      rtcAc_q <= pwdata[MAP_RTC_AC];
    end
  end

  // processor and floating status
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      psr_q <= PSR_RESET;
      fpsr_q <= 16'h0000;
    end else if (anyApply) begin
      psr_q <= PSR_RESET;
      fpsr_q <= fpsr_q & ~FPSR_CLR_MASK;
    end else if (wrAcc && (paddr == ADDR_PSR)) begin
      psr_q <= pwdata[15:0];
      fpsr_q <= pwdata[PSR_FP_LSB +: 16];
    end
  end

  // interrupt-on flag: only the full resets touch it, disable beats enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ion_q <= 1'b0;
    end else if (fullApply || intDisCmd) begin
      ion_q <= 1'b0;
    end else if (intEnCmd) begin
      ion_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prio_q <= PRIO_RESET;
    end else if (anyApply) begin
      prio_q <= PRIO_RESET;
    end else if (wrAcc && (paddr == ADDR_PRIO)) begin
      prio_q <= pwdata[15:0];
    end
  end

  // execution state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ST_CONSOLE;
    end else if (dcFall) begin
      state_q <= ST_DCLOW;
    end else if (fullApply) begin
      state_q <= ST_CONSOLE;
    end else begin
      case (state_q)
        ST_CONSOLE: begin
          if (continueCmd || (restoreEvt && panelLocked)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (restoreEvt && !panelLocked) begin
            state_q <= ST_CONSOLE;
          end
        end
        ST_DCLOW: begin
          state_q <= ST_DCLOW;
        end
        default: begin
          state_q <= ST_CONSOLE;
        end
      endcase
    end
  end

  // resume strobes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      jumpZero_q <= 1'b0;
      prompt_q <= 1'b0;
    end else begin
      jumpZero_q <= !fullApply && ((restoreEvt && panelLocked) ||
        (continueCmd && (state_q == ST_CONSOLE)));
      prompt_q <= !fullApply && restoreEvt && !panelLocked;
    end
  end

  // battery carries the load only while ac is low and software allows it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      battOn_q <= 1'b0;
    end else begin
      battOn_q <= acUndervoltage && batteryPresent && !pctrl_q[PCTRL_NO_BATT];
    end
  end

  assign pfLink.uvRise = uvRise;
  assign pfLink.restore = restoreEvt;
  assign pfLink.fullReset = fullApply;
  assign pfLink.clearPf = clearPfCmd;
  assign pfLink.altMode = pctrl_q[PCTRL_ALT_PF];
  assign pfLink.psuIntEn = pctrl_q[PCTRL_PSU_IE];
  assign pfLink.ionOn = ion_q;

  // read data is captured in the setup cycle so it stands in the access cycle
  always_comb begin
    rdValue = 32'h0000_0000;
    if (paddr == ADDR_PCTRL) begin
      rdValue[2:0] = pctrl_q;
    end else if (paddr == ADDR_MAP) begin
      rdValue[MAP_XLATE_EN] = xlate_q;
      rdValue[MAP_PAGE31_LSB +: 5] = page31_q;
      rdValue[MAP_ECC_CHECK] = eccCheck_q;
      rdValue[MAP_ECC_SNIFF] = eccSniff_q;
      rdValue[MAP_ECC_IE] = eccIe_q;
      rdValue[MAP_TIMER_RUN] = timerRun_q;
      rdValue[MAP_RTC_AC] = rtcAc_q;
    end else if (paddr == ADDR_PRIO) begin
      rdValue[15:0] = prio_q;
    end else if (paddr == ADDR_PSR) begin
      rdValue = {fpsr_q, psr_q};
    end else if (paddr == ADDR_STATUS) begin
      rdValue[6:0] = {battOn_q, state_q, ion_q, pfLink.psuPend, pfLink.pfFlag};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      prdata_q <= rdValue;
    end
  end

  assign prdata = prdata_q;
  assign cacheInvalidate = cacheInv_q;
  assign busyDoneClear = busyDoneClr_q;
  assign translationEnable = xlate_q;
  assign page31Frame = page31_q;
  assign eccCheckEnable = eccCheck_q;
  assign eccSniffEnable = eccSniff_q;
  assign eccIntEnable = eccIe_q;
  assign procStatus = psr_q;
  assign fpStatus = fpsr_q;
  assign interruptOnFlag = ion_q;
  assign ioPriorityMask = prio_q;
  assign intervalTimerRun = timerRun_q;
  assign rtcAcLineSelect = rtcAc_q;
  assign consoleMode = (state_q == ST_CONSOLE);
  assign execStop = (state_q == ST_DCLOW);
  assign jumpThroughZero = jumpZero_q;
  assign consolePrompt = prompt_q;
  assign powerfailFlag = pfLink.pfFlag;
  assign powerfailNmi = pfLink.nmiReq;
  assign psuIntReq = pfLink.psuReq;
  assign batteryBackupOn = battOn_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence lockedRestore;
    restoreEvt && panelLocked && !fullApply;
  endsequence
  sequence unlockedRestore;
    restoreEvt && !panelLocked && !fullApply && (state_q == ST_RUN);
  endsequence

  AST_POWERUP_STATE: assert property (dcRise |=> cacheInv_q && consoleMode && !ion_q)
    else $error("power-up did not reach console with cache invalidated");
  AST_XLATE_OFF: assert property (anyApply |=> !xlate_q && page31_q == PAGE31_RESET)
    else $error("reset left translation on or page 31 wrong");
  AST_ECC_MODES: assert property (anyApply |=> eccCheck_q && eccSniff_q && !eccIe_q)
    else $error("reset left memory checking in wrong mode");
  AST_STATUS_CLR: assert property (anyApply |=> procStatus == PSR_RESET &&
    (fpStatus & FPSR_CLR_MASK) == 16'h0000)
    else $error("reset left status bits set");
  AST_IO_RESET: assert property (ioApply |=> ioPriorityMask == PRIO_RESET &&
    busyDoneClear && !cacheInvalidate)
    else $error("io reset applied wrong set of effects");
  AST_TIMER_RTC: assert property (anyApply |=> !intervalTimerRun && rtcAcLineSelect)
    else $error("reset left timer running or clock source wrong");
  AST_INTDIS_BLOCK: assert property (intDisCmd |=> !powerfailNmi && !psuIntReq && !ion_q)
    else $error("interrupt disable did not block requests");
  AST_DC_STOP: assert property (dcFall |=> execStop && !jumpThroughZero ##1 !cacheInvalidate)
    else $error("dc collapse did not stop execution");
  AST_LOCKED_RESUME: assert property (lockedRestore |=> jumpThroughZero && !consoleMode
    ##1 !jumpThroughZero)
    else $error("locked restore did not jump through zero");
  AST_UNLOCKED_PROMPT: assert property (unlockedRestore |=> consolePrompt && consoleMode &&
    !jumpThroughZero)
    else $error("unlocked restore did not prompt in console");
  AST_BATT_OFF: assert property (pctrl_q[PCTRL_NO_BATT] |=> !batteryBackupOn)
    else $error("battery backup on while disabled");
endmodule

// File: tb/power_ctrl_model.sv
/*
  Behavioural power supply controller and front panel for the reset bench.
  Assumes the bench commands it on ref_clk; pins change one cycle later.
*/
`timescale 1ns/1ps
module power_ctrl_model (
  // clock
  input wire logic ref_clk,
  // bench commands
  input wire logic acFail,
  input wire logic dcFail,
  input wire logic battery,
  input wire logic locked,
  // supply and panel pins
  output logic dcOk,
  output logic acUndervoltage,
  output logic batteryPresent,
  output logic panelLocked
);
  // registered so pins never move in the bench's own time step
  always @(posedge ref_clk) begin
    acUndervoltage <= acFail;
    dcOk <= !dcFail;
    batteryPresent <= battery;
    panelLocked <= locked;
  end
endmodule

// File: tb/system_reset_powerfail_init_bench.sv
/*
  Self-checking bench for the reset and powerfail sequencer.
  Assumes the zero-wait APB slave and register map of the package.
*/
`timescale 1ns/1ps
module system_reset_powerfail_init_bench;
  import rst_pf_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, resetSwitch, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, mapVal, psrVal, prioVal;
  logic acFail, dcFail, battery, locked, dcOk, acUndervoltage, batteryPresent, panelLocked;
  logic cacheInvalidate, busyDoneClear, translationEnable, eccCheckEnable, eccSniffEnable;
  logic eccIntEnable, interruptOnFlag, intervalTimerRun, rtcAcLineSelect, consoleMode;
  logic execStop, jumpThroughZero, consolePrompt, powerfailFlag, powerfailNmi, psuIntReq;
  logic batteryBackupOn, seenInv, seenClr, seenJump, seenPrompt;
  logic [4:0] page31Frame;
  logic [15:0] procStatus, fpStatus, ioPriorityMask;
  int badCount, nChecks, cycles;

  system_reset_powerfail_init dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dcOk(dcOk), .acUndervoltage(acUndervoltage),
    .batteryPresent(batteryPresent), .panelLocked(panelLocked), .resetSwitch(resetSwitch),
    .cacheInvalidate(cacheInvalidate), .busyDoneClear(busyDoneClear),
    .translationEnable(translationEnable), .page31Frame(page31Frame),
    .eccCheckEnable(eccCheckEnable), .eccSniffEnable(eccSniffEnable),
    .eccIntEnable(eccIntEnable), .procStatus(procStatus), .fpStatus(fpStatus),
    .interruptOnFlag(interruptOnFlag), .ioPriorityMask(ioPriorityMask),
    .intervalTimerRun(intervalTimerRun), .rtcAcLineSelect(rtcAcLineSelect),
    .consoleMode(consoleMode), .execStop(execStop), .jumpThroughZero(jumpThroughZero),
    .consolePrompt(consolePrompt), .powerfailFlag(powerfailFlag), .powerfailNmi(powerfailNmi),
    .psuIntReq(psuIntReq), .batteryBackupOn(batteryBackupOn));

  power_ctrl_model psu_u (.ref_clk(ref_clk), .acFail(acFail), .dcFail(dcFail),
    .battery(battery), .locked(locked), .dcOk(dcOk), .acUndervoltage(acUndervoltage),
    .batteryPresent(batteryPresent), .panelLocked(panelLocked));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the bench-wide cycle limit ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pulses are caught over a short window, levels read at its end
  task automatic watch(input int n);
    {seenInv, seenClr, seenJump, seenPrompt} = 4'h0;
    repeat (n) begin
      @(negedge ref_clk);
      seenInv |= cacheInvalidate;
      seenClr |= busyDoneClear;
      seenJump |= jumpThroughZero;
      seenPrompt |= consolePrompt;
    end
  endtask

  task automatic resetLevels(input logic full);
    chk("translation", translationEnable, 0);
    chk("page31", page31Frame, 5'h1f);
    chk("check mode", eccCheckEnable, 1);
    chk("sniff mode", eccSniffEnable, 1);
    chk("ecc irq", eccIntEnable, 0);
    chk("psr", procStatus, 0);
    chk("fpsr", fpStatus, psrVal[31:16] & 16'h003f);
    chk("prio mask", ioPriorityMask, 0);
    chk("busy done clear", seenClr, 1);
    chk("timer", intervalTimerRun, 0);
    chk("rtc line", rtcAcLineSelect, 1);
    if (full) begin
      chk("cache inv", seenInv, 1);
      chk("ion", interruptOnFlag, 0);
      chk("console", consoleMode, 1);
    end
  endtask

  task automatic prog;
    mapVal = ($urandom & 32'h0000_1f00) | 32'h000c_0001;
    psrVal = $urandom | 32'h8000_0001;
    prioVal = $urandom | 32'h0000_0001;
    apb(1'b1, ADDR_MAP, mapVal);
    apb(1'b1, ADDR_PRIO, prioVal);
    apb(1'b1, ADDR_PSR, psrVal);
    apb(1'b1, ADDR_CMD, 32'h0000_0004);
    @(negedge ref_clk);
    chk("xlate set", translationEnable, 1);
    chk("prio set", ioPriorityMask, prioVal[15:0]);
    chk("ion set", interruptOnFlag, 1);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      badCount++;
      reportAndStop();
    end
  end

  initial begin
    {sys_rst, resetSwitch, battery, locked} = 4'b1011;
    {psel, penable, pwrite, acFail, dcFail} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    psrVal = 32'h0;
    void'($urandom(90921));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // skip the edge still under reset, whose pulses would mask a missing power-up apply
    @(posedge ref_clk);
    watch(3);
    resetLevels(1'b1);
    $display("power-up reset test done");
    prog();
    @(posedge ref_clk);
    resetSwitch <= 1'b1;
    @(posedge ref_clk);
    resetSwitch <= 1'b0;
    watch(2);
    resetLevels(1'b1);
    $display("system reset test done");
    prog();
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    watch(2);
    resetLevels(1'b0);
    chk("no cache inv", seenInv, 0);
    $display("io reset test done");
    acFail <= 1'b1;
    watch(4);
    chk("pf flag", powerfailFlag, 1);
    chk("pf nmi", powerfailNmi, 1);
    chk("battery on", batteryBackupOn, 1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status pf", rd[0], 1);
    apb(1'b1, ADDR_CMD, 32'h0000_0002);
    @(negedge ref_clk);
    chk("nmi blocked", powerfailNmi, 0);
    apb(1'b1, ADDR_PCTRL, 32'h0000_0002);
    watch(2);
    chk("battery off", batteryBackupOn, 0);
    acFail <= 1'b0;
    watch(4);
    chk("restore clears", powerfailFlag, 0);
    chk("locked jump", seenJump, 1);
    chk("running", consoleMode, 0);
    $display("powerfail locked test done");
    apb(1'b1, ADDR_PCTRL, 32'h0000_0005);
    apb(1'b1, ADDR_CMD, 32'h0000_0004);
    locked <= 1'b0;
    acFail <= 1'b1;
    watch(4);
    chk("alt no flag", powerfailFlag, 0);
    chk("alt no nmi", powerfailNmi, 0);
    chk("psu req", psuIntReq, 1);
    apb(1'b1, ADDR_CMD, 32'h0000_0008);
    @(negedge ref_clk);
    chk("pf cleared", psuIntReq, 0);
    acFail <= 1'b0;
    watch(4);
    chk("prompt", seenPrompt, 1);
    chk("console", consoleMode, 1);
    apb(1'b1, ADDR_CMD, 32'h0000_0010);
    watch(2);
    chk("continue jump", seenJump, 1);
    $display("powerfail unlocked test done");
    dcFail <= 1'b1;
    watch(4);
    chk("dc stop", execStop, 1);
    chk("dc cache inv", seenInv, 1);
    dcFail <= 1'b0;
    watch(4);
    chk("power-up console", consoleMode, 1);
    apb(1'b0, ADDR_MAP, 32'h0);
    chk("map readback", rd, 32'h0013_1f00);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    $display("dc collapse and bus test done");
    reportAndStop();
  end
endmodule
